// file: tcp_timer16.sv
// How it works
// - Mode 01 runs the counter freely, one step per count clock.
// - Step past FFFFH sets overflow flag and wraps counter to 0000H.
// - Compare match on register b raises irq b, counter keeps running.
// - Register b captures only on pin a valid edge.
// - Register a captures from pin b or reverse edge of pin a.
// - Valid capture edge copies the counter into the capture register.
// - Compare match on register a raises irq a, counter keeps running.
// - Free-running with both compares: output toggles on either match, but not when both match in the same cycle.
// - Free-running, register b capturing: pin a edge captures, raises irq b.
// - Both capturing: pin a edge fills b, pin b edge fills a.
// - Only pin b edges enabled: register b never captures.
// - Mode 11 clears counter on match with a; output is a pulse train.
// - Pulse period is register a plus one count clocks.
// - Active pulse spans register b plus one count clocks.
// - Mode 00 stops counting and zeroes the counter.
// - Mode 10: each pin a valid edge clears counter, counting continues.
// - Reading the counter never disturbs counting.
// - Reverse-phase capture into register a raises no irq a.
`timescale 1ns/100ps
`default_nettype none

module tcp_timer16
    import tcp_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               trigger_pin_a,
    input  wire logic               trigger_pin_b,
    output logic                    wave_out_pin,
    output logic                    wave_out_oe,
    output logic                    event_irq_a,
    output logic                    event_irq_b
);

    // ------------------------------------------------------------
    // Registers and nets
    // ------------------------------------------------------------
    tcp_mode_e      mode_reg;
    logic           overflow_flag;
    tcp_cap_ctrl_s  capture_ctrl_reg;
    logic           output_ctrl_reg;
    tcp_prescale_s  prescale_edge_reg;
    logic [15:0]    count_value_reg;
    logic [15:0]    cap_cmp_reg_a;
    logic [15:0]    cap_cmp_reg_b;
    logic [1:0]     div_reg;
    logic [1:0]     sync1_reg;
    logic [1:0]     sync2_reg;
    logic [1:0]     prev_reg;
    logic           pready_reg;
    logic [31:0]    prdata_reg;
    logic           pslverr_reg;
    logic           wave_reg;
    logic           irq_a_reg;
    logic           irq_b_reg;

    logic           wr_en;
    logic           rd_phase;
    logic           tick;
    logic           running;
    logic [1:0]     rise;
    logic [1:0]     fall;
    logic           edge_a;
    logic           edge_a_opp;
    logic           edge_b;
    logic           match_a;
    logic           match_b;
    logic           cap_a;
    logic           cap_b;
    logic           ovf_event;
    logic           ovf_clear;
    logic [1:0]     opp_cfg;

    function automatic logic edge_hit(input logic r, input logic f, input logic [1:0] cfg);
        logic hit;
        hit = 1'b0;
        case (cfg)
            EDGE_FALL: hit = f;
            EDGE_RISE: hit = r;
            EDGE_BOTH: hit = r | f;
            default:   hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Trigger pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pins;
    assign pins = {trigger_pin_b, trigger_pin_a};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                    prev_reg[gi]  <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pins[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    prev_reg[gi]  <= sync2_reg[gi];
                end
            end
            assign rise[gi] = sync2_reg[gi] & ~prev_reg[gi];
            assign fall[gi] = ~sync2_reg[gi] & prev_reg[gi];
        end
    endgenerate

    // Reverse phase of the pin a selection; both edges stay both edges
    assign opp_cfg    = (prescale_edge_reg.edge_a == EDGE_RISE) ? EDGE_FALL :
                        (prescale_edge_reg.edge_a == EDGE_FALL) ? EDGE_RISE :
                        prescale_edge_reg.edge_a;
    assign edge_a     = edge_hit(rise[0], fall[0], prescale_edge_reg.edge_a);
    assign edge_a_opp = edge_hit(rise[0], fall[0], opp_cfg);
    assign edge_b     = edge_hit(rise[1], fall[1], prescale_edge_reg.edge_b);

    // ------------------------------------------------------------
    // Count clock and events
    // ------------------------------------------------------------
    assign running = (mode_reg != MODE_STOP);

    always_comb begin
        case (prescale_edge_reg.presc)
            PRESC_DIV1: tick = running;
            PRESC_DIV2: tick = running & div_reg[0];
            PRESC_DIV4: tick = running & (&div_reg);
            default:    tick = 1'b0;
        endcase
    end

    assign match_a   = tick & ~capture_ctrl_reg.a_capture
                       & (count_value_reg == cap_cmp_reg_a);
    assign match_b   = tick & ~capture_ctrl_reg.b_capture
                       & (count_value_reg == cap_cmp_reg_b);
    // Register b listens to pin a only, so pin b edges never reach it
    assign cap_b     = running & capture_ctrl_reg.b_capture & edge_a;
    assign cap_a     = running & capture_ctrl_reg.a_capture
                       & (capture_ctrl_reg.reverse_phase_select ? edge_a_opp : edge_b);
    assign ovf_event = tick & (count_value_reg == COUNT_MAX)
                       & (mode_reg == MODE_FREE_RUN || mode_reg == MODE_CLEAR_EDGE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 2'h0;
        end else if (!running) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_reg <= COUNT_ZERO;
        end else begin
            case (mode_reg)
                MODE_STOP: begin
                    count_value_reg <= COUNT_ZERO;
                end
                MODE_FREE_RUN: begin
                    if (prescale_edge_reg.presc == PRESC_PIN_A) begin
                        count_value_reg <= COUNT_ZERO;
                    end else if (tick) begin
                        count_value_reg <= count_value_reg + 16'h0001;
                    end
                end
                MODE_CLEAR_EDGE: begin
                    if (edge_a || prescale_edge_reg.presc == PRESC_PIN_A) begin
                        count_value_reg <= COUNT_ZERO;
                    end else if (tick) begin
                        count_value_reg <= count_value_reg + 16'h0001;
                    end
                end
                MODE_PPG: begin
                    if (prescale_edge_reg.presc == PRESC_PIN_A) begin
                        count_value_reg <= COUNT_ZERO;
                    end else if (tick && count_value_reg == cap_cmp_reg_a) begin
                        count_value_reg <= COUNT_ZERO;
                    end else if (tick) begin
                        count_value_reg <= count_value_reg + 16'h0001;
                    end
                end
                default: begin
                    count_value_reg <= COUNT_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register bus: one wait state, data latched on the same edge that raises pready
    // ------------------------------------------------------------
    assign rd_phase = psel & penable & ~pready_reg;
    assign wr_en    = psel & penable & pready_reg & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= rd_phase;
            if (rd_phase) begin
                pslverr_reg <= 1'b0;
                prdata_reg  <= 32'h0000_0000;
                case (paddr)
                    OFF_MODE_CTRL:   prdata_reg <= {28'h0, mode_reg, 1'b0, overflow_flag};
                    OFF_CAPTURE_CTL: prdata_reg <= {29'h0, capture_ctrl_reg};
                    OFF_OUTPUT_CTL:  prdata_reg <= {31'h0, output_ctrl_reg};
                    OFF_PRESCALE:    prdata_reg <= {24'h0, prescale_edge_reg};
                    OFF_COUNT:       prdata_reg <= {16'h0, count_value_reg};
                    OFF_CAP_CMP_A:   prdata_reg <= {16'h0, cap_cmp_reg_a};
                    OFF_CAP_CMP_B:   prdata_reg <= {16'h0, cap_cmp_reg_b};
                    default:         pslverr_reg <= 1'b1;
                endcase
            end
        end
    end

    assign ovf_clear = wr_en && paddr == OFF_MODE_CTRL && !pwdata[OVF_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg          <= MODE_STOP;
            capture_ctrl_reg  <= CAPTURE_RST;
            output_ctrl_reg   <= 1'b0;
            prescale_edge_reg <= PRESCALE_RST;
        end else if (wr_en) begin
            case (paddr)
                OFF_MODE_CTRL:   mode_reg          <= tcp_mode_e'(pwdata[MODE_LSB +: 2]);
                OFF_CAPTURE_CTL: capture_ctrl_reg  <= pwdata[2:0];
                OFF_OUTPUT_CTL:  output_ctrl_reg   <= pwdata[OUT_EN_BIT];
                OFF_PRESCALE:    prescale_edge_reg <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // A fresh overflow beats a clearing write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag <= 1'b0;
        end else begin
            overflow_flag <= (overflow_flag & ~ovf_clear) | ovf_event;
        end
    end

    // ------------------------------------------------------------
    // Capture/compare registers; a capture beats a software write
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_cmp_reg_a <= CAP_CMP_RST;
        end else if (cap_a) begin
            cap_cmp_reg_a <= count_value_reg;
        end else if (wr_en && paddr == OFF_CAP_CMP_A) begin
            cap_cmp_reg_a <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_cmp_reg_b <= CAP_CMP_RST;
        end else if (cap_b) begin
            cap_cmp_reg_b <= count_value_reg;
        end else if (wr_en && paddr == OFF_CAP_CMP_B) begin
            cap_cmp_reg_b <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupts and wave output
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_a_reg <= 1'b0;
            irq_b_reg <= 1'b0;
        end else begin
            // Reverse-phase captures stay silent so pulse measurement reads cleanly
            irq_a_reg <= match_a | (cap_a & ~capture_ctrl_reg.reverse_phase_select);
            irq_b_reg <= match_b | cap_b;
        end
    end

    // Pulse goes active on the period match and drops on the duty match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_reg <= 1'b0;
        end else if (!running || !output_ctrl_reg) begin
            wave_reg <= 1'b0;
        end else if (mode_reg == MODE_PPG) begin
            if (match_a) begin
                wave_reg <= 1'b1;
            end else if (match_b) begin
                wave_reg <= 1'b0;
            end
        end else if (match_a ^ match_b) begin
            wave_reg <= ~wave_reg;
        end
    end

    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign wave_out_pin = wave_reg;
    assign wave_out_oe  = output_ctrl_reg;
    assign event_irq_a  = irq_a_reg;
    assign event_irq_b  = irq_b_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_FREE_STEP: assert property (
        (mode_reg == MODE_FREE_RUN && tick && !wr_en)
        |=> count_value_reg == 16'($past(count_value_reg) + 16'h0001))
        else $error("free-running counter did not step");

    AST_OVF_SET: assert property (
        (mode_reg == MODE_FREE_RUN && tick && count_value_reg == COUNT_MAX)
        |=> overflow_flag && count_value_reg == COUNT_ZERO)
        else $error("overflow not flagged on wrap");

    AST_OVF_STICKY: assert property (
        (overflow_flag && !ovf_clear) |=> overflow_flag)
        else $error("overflow flag dropped without a clearing write");

    AST_CMP_A_IRQ: assert property (
        match_a && mode_reg == MODE_FREE_RUN |=> event_irq_a ##1 (!event_irq_a || $past(match_a)))
        else $error("compare a interrupt missing or not a pulse");

    AST_CMP_B_KEEP: assert property (
        (match_b && mode_reg == MODE_FREE_RUN && !wr_en)
        |=> event_irq_b && count_value_reg != COUNT_ZERO || $past(count_value_reg) == COUNT_MAX)
        else $error("compare b match did not interrupt or cleared the counter");

    AST_CAP_B: assert property (
        cap_b |=> cap_cmp_reg_b == $past(count_value_reg) && event_irq_b)
        else $error("capture into register b wrong");

    AST_STOP: assert property (
        mode_reg == MODE_STOP |=> count_value_reg == COUNT_ZERO)
        else $error("stopped counter not zero");

    AST_PPG_WRAP: assert property (
        (mode_reg == MODE_PPG && match_a && !wr_en) |=> count_value_reg == COUNT_ZERO
        && (wave_out_pin == output_ctrl_reg))
        else $error("pulse mode did not restart on period match");

    AST_EDGE_CLR: assert property (
        (mode_reg == MODE_CLEAR_EDGE && edge_a && !wr_en) |=> count_value_reg == COUNT_ZERO)
        else $error("pin a edge did not clear counter");

    AST_REV_QUIET: assert property (
        (cap_a && capture_ctrl_reg.reverse_phase_select && capture_ctrl_reg.a_capture)
        |=> !event_irq_a)
        else $error("reverse-phase capture raised interrupt a");

    COV_OVF:  cover property (ovf_event ##1 overflow_flag);
    COV_CAPB: cover property (cap_b && mode_reg == MODE_FREE_RUN);
    COV_PPG:  cover property (mode_reg == MODE_PPG && match_a ##[1:300] match_b);

endmodule // tcp_timer16

`default_nettype wire

// file: tcp_pkg.sv
package tcp_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFF_MODE_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_CAPTURE_CTL = 8'h04;
    localparam logic [7:0]  OFF_OUTPUT_CTL  = 8'h08;
    localparam logic [7:0]  OFF_PRESCALE    = 8'h0c;
    localparam logic [7:0]  OFF_COUNT       = 8'h10;
    localparam logic [7:0]  OFF_CAP_CMP_A   = 8'h14;
    localparam logic [7:0]  OFF_CAP_CMP_B   = 8'h18;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          MODE_LSB        = 2;
    localparam int          OVF_BIT         = 0;
    localparam int          OUT_EN_BIT      = 0;
    localparam logic [15:0] COUNT_MAX       = 16'hffff;
    localparam logic [15:0] COUNT_ZERO      = 16'h0000;
    localparam logic [15:0] CAP_CMP_RST     = 16'h0000;
    localparam logic [7:0]  PRESCALE_RST    = 8'h00;
    localparam logic [2:0]  CAPTURE_RST     = 3'h0;

    // Prescaler selections; the last one would use pin a as count clock
    localparam logic [1:0]  PRESC_DIV1      = 2'h0;
    localparam logic [1:0]  PRESC_DIV2      = 2'h1;
    localparam logic [1:0]  PRESC_DIV4      = 2'h2;
    localparam logic [1:0]  PRESC_PIN_A     = 2'h3;

    // Valid edge selections per trigger pin
    localparam logic [1:0]  EDGE_FALL       = 2'h0;
    localparam logic [1:0]  EDGE_RISE       = 2'h1;
    localparam logic [1:0]  EDGE_BOTH       = 2'h3;

    typedef enum logic [1:0] {
        MODE_STOP       = 2'b00,
        MODE_FREE_RUN   = 2'b01,
        MODE_CLEAR_EDGE = 2'b10,
        MODE_PPG        = 2'b11
    } tcp_mode_e;

    typedef struct packed {
        logic b_capture;
        logic reverse_phase_select;
        logic a_capture;
    } tcp_cap_ctrl_s;

    typedef struct packed {
        logic [1:0] edge_b;
        logic [1:0] edge_a;
        logic [1:0] spare;
        logic [1:0] presc;
    } tcp_prescale_s;

endpackage

// file: tcp_pin_partner.sv
`timescale 1ns/100ps
`default_nettype none

module tcp_pin_partner (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        flip_a,
    input  wire logic        flip_b,
    input  wire logic        wave_out_pin,
    input  wire logic        wave_out_oe,
    output logic             trigger_pin_a,
    output logic             trigger_pin_b,
    output logic [15:0]      period,
    output logic [15:0]      high_len
);
    logic [15:0] run_reg;
    logic        last_reg;

    // ------------------------------------------------------------
    // Pins move only on command, one level change per request
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_pin_a <= 1'b0;
            trigger_pin_b <= 1'b0;
        end else begin
            trigger_pin_a <= trigger_pin_a ^ flip_a;
            trigger_pin_b <= trigger_pin_b ^ flip_b;
        end
    end

    // ------------------------------------------------------------
    // Output watcher: rise to rise and rise to fall, in pclk cycles
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg  <= 16'h0;
            last_reg <= 1'b0;
            period   <= 16'h0;
            high_len <= 16'h0;
        end else begin
            last_reg <= wave_out_pin;
            // Shared with pin a, so only judged while driven
            if (!wave_out_oe) begin
                run_reg <= 16'h0;
            end else if (wave_out_pin && !last_reg) begin
                period  <= run_reg;
                run_reg <= 16'h1;
            end else begin
                run_reg <= run_reg + 16'h1;
                if (!wave_out_pin && last_reg) begin
                    high_len <= run_reg;
                end
            end
        end
    end
endmodule // tcp_pin_partner

`default_nettype wire

// file: tb_timer16_capture_compare_ppg.sv
`timescale 1ns/100ps
`default_nettype none

module tb_timer16_capture_compare_ppg import tcp_pkg::*;;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, wave_out_pin, wave_out_oe, event_irq_a, event_irq_b;
    logic        trigger_pin_a, trigger_pin_b, flip_a = 1'b0, flip_b = 1'b0;
    logic        last_a = 1'b0, last_b = 1'b0, last_w = 1'b0;
    logic [15:0] period, high_len, lfsr = 16'h3, m, n;
    int          errors = 0, total_checks = 0, na = 0, nb = 0, dbl = 0, ntog = 0;

    always #4 pclk = ~pclk;

    tcp_timer16 tcp_timer16_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .trigger_pin_a, .trigger_pin_b, .wave_out_pin,
        .wave_out_oe, .event_irq_a, .event_irq_b);

    tcp_pin_partner tcp_pin_partner_inst (.pclk, .presetn, .flip_a, .flip_b, .wave_out_pin,
        .wave_out_oe, .trigger_pin_a, .trigger_pin_b, .period, .high_len);

    // ------------------------------------------------------------
    // Event counting on the pins
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        if (event_irq_a === 1'b1) na++;
        if (event_irq_b === 1'b1) nb++;
        if ((event_irq_a & last_a) | (event_irq_b & last_b)) dbl++;
        if (wave_out_pin !== last_w) ntog++;
        last_a = event_irq_a;
        last_b = event_irq_b;
        last_w = wave_out_pin;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            errors++;
            $display("mismatch pready expected 1 seen %b", pready);
            wrap_up();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        bus(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        bus(1'b0, a, 32'h0, q, e);
    endtask

    // Stop first so the counter restarts from zero; count clock never taken from pin a
    task automatic cfg(input logic [1:0] md, input logic [2:0] cc, input logic [7:0] ps);
        wr(OFF_MODE_CTRL, 32'h0);
        wr(OFF_CAPTURE_CTL, {29'h0, cc});
        wr(OFF_PRESCALE, {24'h0, ps});
        wr(OFF_MODE_CTRL, {28'h0, md, 2'h0});
    endtask

    task automatic pulse(input logic which);
        if (which) flip_b <= 1'b1;
        else flip_a <= 1'b1;
        @(posedge pclk);
        flip_a <= 1'b0;
        flip_b <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r, c0, c1;
        logic        e;
        time         t0;
        int          a0, b0, tg;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0, r, e);
            chk("reset value", 32'h0, r);
            chk("slave error", 32'(i == 7), {31'h0, e});
        end
        wr(OFF_COUNT, 32'h1234);
        rd(OFF_COUNT, r);
        chk("stopped count", 32'h0, r);
        wr(OFF_MODE_CTRL, 32'h4);
        rd(OFF_COUNT, c0);
        t0 = $time;
        rd(OFF_COUNT, c1);
        chk("count rate", c0 + 32'(($time - t0) / 8), c1);
        repeat (32'hffff - c1 - 30) @(posedge pclk);
        rd(OFF_MODE_CTRL, r);
        chk("overflow early", 32'h4, r);
        repeat (40) @(posedge pclk);
        rd(OFF_MODE_CTRL, r);
        chk("overflow set", 32'h5, r);
        rd(OFF_COUNT, r);
        chk("count wrapped", 32'h1, 32'(r < 100));
        wr(OFF_MODE_CTRL, 32'h5);
        rd(OFF_MODE_CTRL, r);
        chk("overflow kept", 32'h5, r);
        wr(OFF_MODE_CTRL, 32'h4);
        rd(OFF_MODE_CTRL, r);
        chk("overflow cleared", 32'h4, r);
        cfg(2'h1, 3'h0, 8'h02);
        rd(OFF_COUNT, c0);
        t0 = $time;
        rd(OFF_COUNT, c1);
        chk("count rate div4", c0 + 32'(($time - t0) / 32), c1);
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            m = (i < 2) ? {8'h0, lfsr[7:0]} + 16'h50 : {10'h0, lfsr[5:0]} + 16'h8;
            n = (i < 2) ? {10'h0, lfsr[13:8]} + 16'h4 : {13'h0, lfsr[10:8]};
            if (i == 2) n = m - 16'h1;
            cfg(2'h0, 3'h0, 8'h0);
            wr(OFF_CAP_CMP_A, {16'h0, m});
            wr(OFF_CAP_CMP_B, {16'h0, n});
            wr(OFF_OUTPUT_CTL, 32'h1);
            a0 = na;
            b0 = nb;
            tg = ntog;
            wr(OFF_MODE_CTRL, (i < 2) ? 32'h4 : 32'hc);
            repeat ((i < 2) ? int'(m) + 20 : 3 * int'(m) + 12) @(posedge pclk);
            rd(OFF_COUNT, r);
            if (i < 2) begin
                chk("count kept", 32'h1, 32'(r > m));
                chk("irq a", 32'h1, 32'(na - a0));
                chk("irq b", 32'h1, 32'(nb - b0));
                chk("toggles", 32'h2, 32'(ntog - tg));
            end else begin
                chk("count bounded", 32'h1, 32'(r <= m));
                chk("period", {16'h0, m} + 32'h1, {16'h0, period});
                chk("high width", {16'h0, n} + 32'h1, {16'h0, high_len});
            end
        end
        wr(OFF_OUTPUT_CTL, 32'h0);
        chk("output enable off", 32'h0, {31'h0, wave_out_oe});
        cfg(2'h1, 3'h4, 8'h10);
        rd(OFF_COUNT, c0);
        b0 = nb;
        pulse(1'b0);
        rd(OFF_COUNT, c1);
        rd(OFF_CAP_CMP_B, r);
        chk("capture b", 32'h1, 32'(r > c0 && r < c1));
        chk("irq b capture", 32'h1, 32'(nb - b0));
        pulse(1'b0);
        pulse(1'b1);
        pulse(1'b1);
        rd(OFF_CAP_CMP_B, c0);
        chk("capture b held", r, c0);
        chk("irq b held", 32'h1, 32'(nb - b0));
        cfg(2'h1, 3'h5, 8'hd0);
        a0 = na;
        b0 = nb;
        rd(OFF_COUNT, c0);
        pulse(1'b1);
        pulse(1'b0);
        rd(OFF_COUNT, c1);
        rd(OFF_CAP_CMP_A, r);
        chk("capture a", 32'h1, 32'(r > c0 && r < c1));
        rd(OFF_CAP_CMP_B, r);
        chk("capture b both", 32'h1, 32'(r > c0 && r < c1));
        chk("irq pair", 32'h2, 32'(na - a0 + nb - b0));
        cfg(2'h1, 3'h5, 8'he0);
        b0 = nb;
        rd(OFF_CAP_CMP_B, c0);
        pulse(1'b0);
        rd(OFF_CAP_CMP_B, r);
        chk("no capture b", c0, r);
        chk("no irq b", 32'h0, 32'(nb - b0));
        cfg(2'h1, 3'h3, 8'h10);
        a0 = na;
        pulse(1'b0);
        rd(OFF_COUNT, c0);
        pulse(1'b0);
        rd(OFF_COUNT, c1);
        rd(OFF_CAP_CMP_A, r);
        chk("reverse capture", 32'h1, 32'(r > c0 && r < c1));
        chk("reverse no irq", 32'h0, 32'(na - a0));
        cfg(2'h2, 3'h0, 8'h11);
        repeat (200) @(posedge pclk);
        pulse(1'b0);
        rd(OFF_COUNT, r);
        chk("edge clear", 32'h1, 32'(r < 20));
        chk("single pulse", 32'h0, 32'(dbl));
        wrap_up();
    end
endmodule // tb_timer16_capture_compare_ppg

`default_nettype wire
